/* rtl/io_port_consts.svh */
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

// host address layout: bits 6:4 pick the port, bits 3:0 pick the register
`define PORT_FIELD_HI      6
`define PORT_FIELD_LO      4
`define REG_FIELD_HI       3
`define REG_FIELD_LO       0

// register codes inside a port
`define REG_PIN_INPUT      4'h0
`define REG_PIN_OUTPUT     4'h1
`define REG_DIRECTION      4'h2
`define REG_DRIVE_SELECT   4'h3
`define REG_CONTROL        4'h4
`define REG_CELL_VALUE     4'h5
`define REG_CELL_MASK      4'h6
`define REG_INPUT_CELL     4'h7
`define REG_ENABLE_VIEW    4'h8

// which ports carry each register, bit n is port n (A=0 .. G=6)
`define PORTS_ALL          7'h7f
`define PORTS_CONTROL      7'h70
`define PORTS_DRIVE        7'h5b
`define PORTS_CELL         7'h03
`define PORTS_INPUT_CELL   7'h07
`define PORTS_ENABLE_VIEW  7'h27

// reset values
`define RESET_CONFIG       8'h00
`define RESET_CELL_MASK    8'h00
`define RESET_CELL_VALUE   8'h00
`define RESET_READ_DATA    8'h00

// port d is four pins wide
`define PORT_D_PINS        4'hf
`define PORT_D_INDEX       3'h3

`endif

/* rtl/io_port_pkg.sv */
`default_nettype none
package io_port_pkg;

   typedef logic [7:0] port_byte_t;

   typedef enum logic [2:0]
   {
      PORT_A = 3'b000,
      PORT_B = 3'b001,
      PORT_C = 3'b010,
      PORT_D = 3'b011,
      PORT_E = 3'b100,
      PORT_F = 3'b101,
      PORT_G = 3'b110
   } port_id_e;

endpackage : io_port_pkg
`default_nettype wire

/* rtl/pin_sync.sv */
`default_nettype none
// three stages; a new level is passed on only once the last two stages agree
module pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             sys_rst,
   // raw and filtered levels
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // a bit moves only where the last two stages agree, so a one-cycle glitch never reaches the logic
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         level <= '0;
      else
         level <= (stage3 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
   end

endmodule : pin_sync
`default_nettype wire

/* rtl/io_port_data_path.sv */
// Summary of operation
// RULE_01: host write to output cell location loads data into every unmasked cell flip-flop
// RULE_02: one mask bit per output cell flip-flop; a set bit blocks host loading
// RULE_03: all load mask bits reset to zero, so every cell accepts host writes
// RULE_04: host read of the output cell location returns current cell flip-flop outputs
// RULE_05: input cells store pin levels, feed the logic input bus and are host readable
// RULE_06: load mask register exists on ports a and b only, readable and writable
// RULE_07: read-only driver enable view exists on ports a, b, c and f
// RULE_08: driver enable view bit 1 means driving, 0 means tri-stated input
// RULE_09: port a/b cells route to their pins; external selects route to c or f
// RULE_10: ports a, b, c input cells also accept high-order host address inputs
// RULE_11: every port a pin can be made an open-drain output
// RULE_12: port d has four pins feeding logic directly, no input cells
// RULE_13: port d pins give address strobe, logic clock and high-byte write enable
// RULE_14: configured device select driven high disables flash, sram and register block
// RULE_15: port f can act as bidirectional host data bits 7 to 0
// RULE_16: port g can act as bidirectional host data bits 15 to 8
// RULE_17: ports e, f and g can drive latched host address bits
// RULE_18: pe6 can be battery supply input, pe7 the on-battery output flag
// RULE_19: direction 1 or active enable term makes the pin an output
// RULE_20: pin output register holds host data, drives enabled pins, reads back
// RULE_21: on ports e, f, g control 0 picks general io, 1 address output
// RULE_22: host read of pin input register returns live pin levels
// RULE_23: bit n maps to pin n; writes take effect at the end of the write cycle
`default_nettype none
`include "io_port_consts.svh"
module io_port_data_path
   import io_port_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // host register access
   input  wire logic [7:0]  hostAddr,
   input  wire logic        hostWrite,
   input  wire logic        hostRead,
   input  wire logic [7:0]  hostWdata,
   output logic      [7:0]  hostRdata,
   output logic             hostRvalid,
   // fixed configuration
   input  wire logic [7:0]  cellRouteA,
   input  wire logic [7:0]  cellRouteB,
   input  wire logic [7:0]  selectRouteC,
   input  wire logic [7:0]  selectRouteF,
   input  wire logic        chipSelectEnable,
   input  wire logic        batteryInputEnable,
   input  wire logic        batteryFlagEnable,
   input  wire logic        dataPortEnable,
   // programmable logic side
   input  wire logic [7:0]  oeTermA,
   input  wire logic [7:0]  oeTermB,
   input  wire logic [7:0]  oeTermC,
   input  wire logic [7:0]  oeTermF,
   input  wire logic [7:0]  cellNextA,
   input  wire logic [7:0]  cellNextB,
   input  wire logic [7:0]  externalSelectTerms,
   output logic      [23:0] inputCellBus,
   output logic      [3:0]  portDLogic,
   // host bus side of the device
   input  wire logic [15:0] addressBus,
   input  wire logic [15:0] hostDataOut,
   input  wire logic        hostDataDrive,
   input  wire logic        onBattery,
   output logic      [15:0] hostDataIn,
   output logic             addressLatchStrobe,
   output logic             logicClockInput,
   output logic             highByteWriteEnable,
   output logic             deviceDisabled,
   // pins
   input  wire logic [7:0]  portAIn,
   output logic      [7:0]  portAOut,
   output logic      [7:0]  portAOe,
   input  wire logic [7:0]  portBIn,
   output logic      [7:0]  portBOut,
   output logic      [7:0]  portBOe,
   input  wire logic [7:0]  portCIn,
   output logic      [7:0]  portCOut,
   output logic      [7:0]  portCOe,
   input  wire logic [3:0]  portDIn,
   output logic      [3:0]  portDOut,
   output logic      [3:0]  portDOe,
   input  wire logic [7:0]  portEIn,
   output logic      [7:0]  portEOut,
   output logic      [7:0]  portEOe,
   input  wire logic [7:0]  portFIn,
   output logic      [7:0]  portFOut,
   output logic      [7:0]  portFOe,
   input  wire logic [7:0]  portGIn,
   output logic      [7:0]  portGOut,
   output logic      [7:0]  portGOe
);

   // true when the access addresses register code reg of a port that owns it
   function automatic logic regHit(input logic [7:0] addr, input logic [3:0] code, input logic [6:0] owners);
      logic [2:0] port;
      port = addr[`PORT_FIELD_HI:`PORT_FIELD_LO];
      regHit = (addr[`REG_FIELD_HI:`REG_FIELD_LO] == code) && (port != 3'h7) && owners[port];
   endfunction : regHit

   // pin stage: open drain only ever pulls low
   function automatic logic [15:0] pinStage(input port_byte_t value, input port_byte_t enable,
                                            input port_byte_t openDrain);
      port_byte_t oe;
      oe = enable & ~(openDrain & value);
      pinStage = {value & ~openDrain, oe};
   endfunction : pinStage

   // synchronised pin levels
   logic [51:0] pinLevel;
   logic [3:0]  pinD;
   port_byte_t  pinA, pinB, pinC, pinE, pinF, pinG;

   pin_sync #(
      .WIDTH (52)
   ) u_pin_sync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .raw     ({portGIn, portFIn, portEIn, portDIn, portCIn, portBIn, portAIn}),
      .level   (pinLevel)
   );

   assign {pinG, pinF, pinE, pinD, pinC, pinB, pinA} = pinLevel;

   // port d dedicated inputs go straight to the logic
   assign portDLogic          = pinD;                                           // RULE_12
   assign addressLatchStrobe  = pinD[0];                                        // RULE_13
   assign logicClockInput     = pinD[1];                                        // RULE_13
   assign highByteWriteEnable = pinD[3];                                        // RULE_13
   // the selected device gates its own register block off the host
   assign deviceDisabled      = chipSelectEnable & pinD[2];                     // RULE_14

   // host access decode
   logic       writeOk, readOk;
   logic [2:0] hostPort;

   assign writeOk  = hostWrite & ~deviceDisabled;                               // RULE_14
   assign readOk   = hostRead & ~deviceDisabled;                                // RULE_14
   assign hostPort = hostAddr[`PORT_FIELD_HI:`PORT_FIELD_LO];

   // configuration registers, one entry per port
   port_byte_t pinOutput [7];
   port_byte_t direction [7];
   port_byte_t driveSel  [7];
   port_byte_t control   [7];

   // writes land on the clock edge that ends the one-cycle write strobe
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (int p = 0; p < 7; p++)
         begin
            pinOutput[p] <= `RESET_CONFIG;
            direction[p] <= `RESET_CONFIG;
            driveSel[p]  <= `RESET_CONFIG;
            control[p]   <= `RESET_CONFIG;
         end
      end
      else if (writeOk)
      begin
         if (regHit(hostAddr, `REG_PIN_OUTPUT, `PORTS_ALL))                    // RULE_20
            pinOutput[hostPort] <= hostWdata;                                  // RULE_23
         if (regHit(hostAddr, `REG_DIRECTION, `PORTS_ALL))                     // RULE_19
            direction[hostPort] <= hostWdata;
         if (regHit(hostAddr, `REG_DRIVE_SELECT, `PORTS_DRIVE))                // RULE_11
            driveSel[hostPort] <= hostWdata;
         if (regHit(hostAddr, `REG_CONTROL, `PORTS_CONTROL))                   // RULE_21
            control[hostPort] <= hostWdata;
      end
   end

   // rising edge of the logic clock pin, seen on the system clock
   logic logicClockPrev, logicClockRise;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         logicClockPrev <= 1'b0;
      else
         logicClockPrev <= pinD[1];
   end

   assign logicClockRise = pinD[1] & ~logicClockPrev;

   // load masks and output cells of ports a and b
   port_byte_t cellMask  [2];
   port_byte_t cellValue [2];
   port_byte_t cellNext  [2];

   assign cellNext = '{cellNextA, cellNextB};

   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_cell
         logic hostLoad;
         assign hostLoad = writeOk && regHit(hostAddr, `REG_CELL_VALUE, `PORTS_CELL) && (hostPort == c);

         always_ff @(posedge clock)
         begin
            if (sys_rst)
               cellMask[c] <= `RESET_CELL_MASK;                                 // RULE_03
            else if (writeOk && regHit(hostAddr, `REG_CELL_MASK, `PORTS_CELL) && (hostPort == c))
               cellMask[c] <= hostWdata;                                        // RULE_06
         end

         // a host load of an unmasked bit overrides the logic clock load in the same cycle
         always_ff @(posedge clock)
         begin
            if (sys_rst)
               cellValue[c] <= `RESET_CELL_VALUE;
            else
            begin
               for (int b = 0; b < 8; b++)
               begin
                  if (hostLoad && !cellMask[c][b])                              // RULE_02
                     cellValue[c][b] <= hostWdata[b];                           // RULE_01
                  else if (logicClockRise)
                     cellValue[c][b] <= cellNext[c][b];
               end
            end
         end
      end
   endgenerate

   // input cells store pin levels, including high-order address fed in on these pins
   port_byte_t inputCell [3];

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         for (int p = 0; p < 3; p++)
            inputCell[p] <= `RESET_CONFIG;
      end
      else if (logicClockRise)
      begin
         inputCell[0] <= pinA;                                                  // RULE_05
         inputCell[1] <= pinB;                                                  // RULE_10
         inputCell[2] <= pinC;                                                  // RULE_10
      end
   end

   assign inputCellBus = {inputCell[2], inputCell[1], inputCell[0]};            // RULE_05

   // latched host address, transparent while the strobe is high
   logic [15:0] latchedAddr;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         latchedAddr <= 16'h0000;
      else if (pinD[0])
         latchedAddr <= addressBus;
   end

   // output selection and enables per port
   port_byte_t valueA, valueB, valueC, valueE, valueEBase, valueF, valueG;
   port_byte_t enableA, enableB, enableC, enableE, enableF, enableG;
   port_byte_t addrLowMode, batteryMask;

   assign valueA  = (cellRouteA & cellValue[0]) | (~cellRouteA & pinOutput[PORT_A]);        // RULE_09
   assign valueB  = (cellRouteB & cellValue[1]) | (~cellRouteB & pinOutput[PORT_B]);        // RULE_09
   assign valueC  = (selectRouteC & externalSelectTerms) | (~selectRouteC & pinOutput[PORT_C]); // RULE_09
   assign enableA = direction[PORT_A] | oeTermA | cellRouteA;                              // RULE_19
   assign enableB = direction[PORT_B] | oeTermB | cellRouteB;                              // RULE_19
   assign enableC = direction[PORT_C] | oeTermC | selectRouteC;                            // RULE_19

   // pe6 as supply input is never driven; pe7 may carry the battery flag
   assign batteryMask = {1'b0, batteryInputEnable, 6'h00};
   assign addrLowMode = control[PORT_E];
   assign valueEBase  = (addrLowMode & latchedAddr[7:0]) | (~addrLowMode & pinOutput[PORT_E]); // RULE_17
   assign valueE      = batteryFlagEnable ? {onBattery, valueEBase[6:0]} : valueEBase;         // RULE_18
   assign enableE     = (direction[PORT_E] | control[PORT_E] | {batteryFlagEnable, 7'h00}) & ~batteryMask; // RULE_18

   // data port mode hands f and g to the host data bus
   always_comb
   begin
      if (dataPortEnable)
      begin
         valueF  = hostDataOut[7:0];                                            // RULE_15
         valueG  = hostDataOut[15:8];                                           // RULE_16
         enableF = {8{hostDataDrive}};                                          // RULE_15
         enableG = {8{hostDataDrive}};                                          // RULE_16
      end
      else
      begin
         valueF  = (control[PORT_F] & latchedAddr[7:0])                          // RULE_21
                 | (~control[PORT_F] & selectRouteF & externalSelectTerms)       // RULE_09
                 | (~control[PORT_F] & ~selectRouteF & pinOutput[PORT_F]);
         valueG  = (control[PORT_G] & latchedAddr[15:8]) | (~control[PORT_G] & pinOutput[PORT_G]); // RULE_17
         enableF = direction[PORT_F] | oeTermF | control[PORT_F] | selectRouteF; // RULE_19
         enableG = direction[PORT_G] | control[PORT_G];
      end
   end

   assign hostDataIn = {pinG, pinF};                                            // RULE_16

   // pin stages; port c and f have no open-drain option, data port stays push-pull
   assign {portAOut, portAOe} = pinStage(valueA, enableA, driveSel[PORT_A]);    // RULE_11
   assign {portBOut, portBOe} = pinStage(valueB, enableB, driveSel[PORT_B]);
   assign {portCOut, portCOe} = pinStage(valueC, enableC, 8'h00);
   assign {portEOut, portEOe} = pinStage(valueE, enableE, driveSel[PORT_E]);
   assign {portFOut, portFOe} = pinStage(valueF, enableF, 8'h00);
   assign {portGOut, portGOe} = pinStage(valueG, enableG, dataPortEnable ? 8'h00 : driveSel[PORT_G]);

   // port d: four output bits only
   logic [3:0] enableD, openD;

   assign enableD  = direction[PORT_D][3:0] & `PORT_D_PINS;                      // RULE_12
   assign openD    = driveSel[PORT_D][3:0];
   assign portDOut = pinOutput[PORT_D][3:0] & ~openD;
   assign portDOe  = enableD & ~(openD & pinOutput[PORT_D][3:0]);

   // actual driver enables as seen at the pins, for the enable view
   port_byte_t driverView [7];

   assign driverView = '{portAOe, portBOe, portCOe, 8'h00, 8'h00, portFOe, 8'h00};     // RULE_08

   // read mux
   port_byte_t pinView [7];
   port_byte_t readValue;

   assign pinView = '{pinA, pinB, pinC, {4'h0, pinD}, pinE, pinF, pinG};

   always_comb
   begin
      readValue = `RESET_READ_DATA;
      if (regHit(hostAddr, `REG_PIN_INPUT, `PORTS_ALL))
         readValue = pinView[hostPort];                                         // RULE_22
      else if (regHit(hostAddr, `REG_PIN_OUTPUT, `PORTS_ALL))
         readValue = (hostPort == `PORT_D_INDEX) ? {4'h0, pinOutput[hostPort][3:0]} : pinOutput[hostPort]; // RULE_20
      else if (regHit(hostAddr, `REG_DIRECTION, `PORTS_ALL))
         readValue = (hostPort == `PORT_D_INDEX) ? {4'h0, direction[hostPort][3:0]} : direction[hostPort];
      else if (regHit(hostAddr, `REG_DRIVE_SELECT, `PORTS_DRIVE))
         readValue = (hostPort == `PORT_D_INDEX) ? {4'h0, driveSel[hostPort][3:0]} : driveSel[hostPort];
      else if (regHit(hostAddr, `REG_CONTROL, `PORTS_CONTROL))
         readValue = control[hostPort];
      else if (regHit(hostAddr, `REG_CELL_VALUE, `PORTS_CELL))
         readValue = cellValue[hostPort[0]];                                    // RULE_04
      else if (regHit(hostAddr, `REG_CELL_MASK, `PORTS_CELL))
         readValue = cellMask[hostPort[0]];                                     // RULE_06
      else if (regHit(hostAddr, `REG_INPUT_CELL, `PORTS_INPUT_CELL))
         readValue = inputCell[hostPort[1:0]];                                  // RULE_05
      else if (regHit(hostAddr, `REG_ENABLE_VIEW, `PORTS_ENABLE_VIEW))
         readValue = driverView[hostPort];                                      // RULE_07
   end

   // read data is registered so the host sees a stable byte one cycle after the strobe
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         hostRdata  <= `RESET_READ_DATA;
         hostRvalid <= 1'b0;
      end
      else
      begin
         hostRvalid <= readOk;
         if (readOk)
            hostRdata <= readValue;
      end
   end

endmodule : io_port_data_path
`default_nettype wire

/* verification/io_port_data_path_monitor.sv */
`default_nettype none
module io_port_data_path_monitor
   import io_port_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       sys_rst,
   // watched ports
   input wire logic [7:0] hostAddr,
   input wire logic       hostRead,
   input wire logic [7:0] hostRdata,
   input wire logic       hostRvalid,
   input wire logic       deviceDisabled,
   input wire logic [7:0] oeTermC,
   input wire logic [7:0] selectRouteC,
   input wire logic [7:0] portCOe,
   input wire logic       dataPortEnable,
   input wire logic       hostDataDrive,
   input wire logic [7:0] portFOe,
   input wire logic [7:0] portGOe,
   input wire logic       batteryInputEnable,
   input wire logic       batteryFlagEnable,
   input wire logic [7:0] portEOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   AST_READ_ANSWER: assert property (hostRvalid == $past(hostRead && !deviceDisabled))
      else $error("read answer pulse wrong");
   AST_READ_HOLD: assert property (!hostRvalid |-> $stable(hostRdata))
      else $error("read data moved without a read");
   AST_VIEW_C: assert property (hostRead && hostAddr == 8'h28 && !deviceDisabled
      |=> hostRdata == $past(portCOe)) else $error("enable view differs from driver enables");
   AST_SELECT_KEEP: assert property (hostRead && deviceDisabled |=> !hostRvalid && $stable(hostRdata))
      else $error("disabled device answered a read");
   AST_OE_TERM: assert property ((oeTermC & ~portCOe) == 8'h00)
      else $error("enable term did not drive pin");
   AST_SELECT_ROUTE: assert property ((selectRouteC & ~portCOe) == 8'h00)
      else $error("routed select pin not driven");
   AST_DATA_PORT: assert property (dataPortEnable && hostDataDrive
      && $past(dataPortEnable && hostDataDrive) |-> portFOe == 8'hff && portGOe == 8'hff)
      else $error("data port not driving");
   AST_BATTERY_IN: assert property (batteryInputEnable && $past(batteryInputEnable) |-> !portEOe[6])
      else $error("supply input pin driven");
   AST_BATTERY_FLAG: assert property (batteryFlagEnable && $past(batteryFlagEnable) |-> portEOe[7])
      else $error("battery flag pin not driven");
   cover property (hostRvalid && hostRdata != 8'h00);
   cover property (deviceDisabled && hostRead);
   cover property (dataPortEnable && hostDataDrive);
endmodule : io_port_data_path_monitor
bind io_port_data_path io_port_data_path_monitor io_port_data_path_monitor_i (.clock(clock), .sys_rst(sys_rst),
   .hostAddr(hostAddr), .hostRead(hostRead), .hostRdata(hostRdata), .hostRvalid(hostRvalid),
   .deviceDisabled(deviceDisabled), .oeTermC(oeTermC),
   .selectRouteC(selectRouteC), .portCOe(portCOe), .dataPortEnable(dataPortEnable),
   .hostDataDrive(hostDataDrive), .portFOe(portFOe), .portGOe(portGOe), .batteryInputEnable(batteryInputEnable),
   .batteryFlagEnable(batteryFlagEnable), .portEOe(portEOe));
`default_nettype wire

/* verification/host_bus_model.sv */
`default_nettype none
module host_bus_model
   import io_port_pkg::*;
(
   // clock
   input  wire logic       clock,
   // host bus
   output logic      [7:0] hostAddr,
   output logic            hostWrite,
   output logic            hostRead,
   output logic      [7:0] hostWdata,
   input  wire logic [7:0] hostRdata,
   input  wire logic       hostRvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {hostAddr, hostWrite, hostRead, hostWdata} = '0;
   end
   // released lines show inverted values so a stale bus never looks valid
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      {hostAddr, hostWdata, hostWrite} = {addr, data, 1'b1};
      @(negedge clock);
      {hostAddr, hostWdata, hostWrite} = {~addr, ~data, 1'b0};
   endtask : write_reg
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
      @(negedge clock);
      {hostAddr, hostRead} = {addr, 1'b1};
      @(negedge clock);
      data = hostRdata;
      valid = hostRvalid;
      {hostAddr, hostRead} = {~addr, 1'b0};
   endtask : read_reg
endmodule : host_bus_model
`default_nettype wire

/* verification/io_port_data_path_tb.sv */
`default_nettype none
`define CHK(got, exp) \
   begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module io_port_data_path_tb
   import io_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, sys_rst, hostWrite, hostRead, hostRvalid, chipSelectEnable, batteryInputEnable;
   logic        batteryFlagEnable, dataPortEnable, hostDataDrive, onBattery, addressLatchStrobe;
   logic        logicClockInput, highByteWriteEnable, deviceDisabled, rdValid;
   logic [7:0]  hostAddr, hostWdata, hostRdata, cellRouteA, cellRouteB, selectRouteC, selectRouteF, rdData;
   logic [7:0]  oeTermA, oeTermB, oeTermC, oeTermF, cellNextA, cellNextB, externalSelectTerms;
   logic [7:0]  portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, portCIn, portCOut, portCOe;
   logic [7:0]  portEIn, portEOut, portEOe, portFIn, portFOut, portFOe, portGIn, portGOut, portGOe;
   logic [3:0]  portDIn, portDOut, portDOe, portDLogic;
   logic [15:0] addressBus, hostDataOut, hostDataIn;
   logic [23:0] inputCellBus;
   int          bad_count, checks_done;
   io_port_data_path io_port_data_path_i (.*);
   host_bus_model host_bus_model_i (.clock(clock), .hostAddr(hostAddr), .hostWrite(hostWrite),
      .hostRead(hostRead), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostRvalid(hostRvalid));
   always #2.5 clock = ~clock;
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      host_bus_model_i.write_reg(addr, data);
   endtask : wr
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      host_bus_model_i.read_reg(addr, rdData, rdValid);
      `CHK(rdValid, 1'b1)
      `CHK(rdData, exp)
   endtask : rd_chk
   // pins pass a synchroniser of four edges; six leaves margin
   task automatic settle();
      repeat (6) @(negedge clock);
   endtask : settle
   task automatic tally_and_finish();
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic test_reset_state();
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h16, 8'h00);
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h70, 8'h00);
   endtask : test_reset_state
   task automatic test_cell_mask();
      wr(8'h06, 8'hf0);
      wr(8'h05, 8'haa);
      rd_chk(8'h05, 8'h0a);
      rd_chk(8'h06, 8'hf0);
      wr(8'h06, 8'h00);
      wr(8'h05, 8'h55);
      rd_chk(8'h05, 8'h55);
      wr(8'h26, 8'hff);
      rd_chk(8'h26, 8'h00);
      cellRouteB = 8'hff;
      wr(8'h15, 8'h3c);
      `CHK({portBOut, portBOe}, 16'h3cff)
   endtask : test_cell_mask
   task automatic test_direction();
      {oeTermA, oeTermC} = 16'h8033;
      wr(8'h01, 8'h5a);
      wr(8'h02, 8'h0f);
      `CHK(portAOe, 8'h8f)
      `CHK(portAOut & portAOe, 8'h0a)
      rd_chk(8'h08, 8'h8f);
      rd_chk(8'h01, 8'h5a);
      rd_chk(8'h28, 8'h33);
      rd_chk(8'h48, 8'h00);
      wr(8'h03, 8'h0f);
      `CHK(portAOe, 8'h85)
   endtask : test_direction
   task automatic test_pin_input();
      logic [7:0] pat [7];
      pat = '{8'h11, 8'h22, 8'h33, 8'h09, 8'h55, 8'h66, 8'h77};
      {portAIn, portBIn, portCIn, portDIn, portEIn, portFIn, portGIn} = {pat[0], pat[1], pat[2], pat[3][3:0],
         pat[4], pat[5], pat[6]};
      settle();
      for (int p = 0; p < 7; p++)
         rd_chk({1'b0, p[2:0], 4'h0}, pat[p]);
      `CHK({addressLatchStrobe, highByteWriteEnable, portDLogic}, 6'h39)
      `CHK(hostDataIn, 16'h7766)
   endtask : test_pin_input
   task automatic test_address_out();
      {addressBus, batteryInputEnable, batteryFlagEnable, onBattery} = {16'hbeef, 3'b111};
      settle();
      wr(8'h44, 8'hff);
      wr(8'h64, 8'hff);
      `CHK(portEOut[5:0], 6'h2f)
      `CHK({portGOut, portGOe}, 16'hbeff)
      wr(8'h44, 8'h00);
      `CHK(portEOe, 8'h80)
      `CHK(portEOut[7], 1'b1)
   endtask : test_address_out
   task automatic test_data_port();
      {dataPortEnable, hostDataDrive, hostDataOut} = {2'b11, 16'ha55a};
      {selectRouteC, selectRouteF, externalSelectTerms} = 24'h0fff3c;
      repeat (2) @(negedge clock);
      `CHK(portFOut, 8'h5a)
      `CHK(portGOut, 8'ha5)
      dataPortEnable = 1'b0;
      repeat (2) @(negedge clock);
      `CHK({portFOut, portFOe}, 16'h3cff)
      `CHK({portCOut, portCOe}, 16'h0c3f)
   endtask : test_data_port
   task automatic test_device_select();
      {chipSelectEnable, portDIn} = 5'h1d;
      settle();
      `CHK(deviceDisabled, 1'b1)
      wr(8'h06, 8'hff);
      host_bus_model_i.read_reg(8'h06, rdData, rdValid);
      `CHK(rdValid, 1'b0)
      portDIn = 4'h9;
      settle();
      rd_chk(8'h06, 8'h00);
   endtask : test_device_select
   task automatic test_logic_clock();
      {cellNextA, cellNextB, portDIn} = {16'h9669, 4'hb};
      settle();
      `CHK({logicClockInput, inputCellBus}, 25'h1332211)
      rd_chk(8'h27, 8'h33);
      rd_chk(8'h15, 8'h69);
      wr(8'h31, 8'hf5);
      wr(8'h32, 8'hff);
      `CHK({portDOut, portDOe}, 8'h5f)
      rd_chk(8'h31, 8'h05);
   endtask : test_logic_clock
   initial
   begin
      {clock, sys_rst, chipSelectEnable, batteryInputEnable, batteryFlagEnable} = 5'h08;
      {dataPortEnable, hostDataDrive, onBattery, portDIn, addressBus, hostDataOut} = '0;
      {cellRouteA, cellRouteB, selectRouteC, selectRouteF, oeTermA, oeTermB, oeTermC, oeTermF} = '0;
      {cellNextA, cellNextB, externalSelectTerms, portAIn, portBIn, portCIn, portEIn, portFIn, portGIn} = '0;
      bad_count = 0;
      checks_done = 0;
      repeat (20) @(negedge clock);
      sys_rst = 1'b0;
      test_reset_state();
      test_cell_mask();
      test_direction();
      test_pin_input();
      test_address_out();
      test_data_port();
      test_device_select();
      test_logic_clock();
      tally_and_finish();
   end
   // about twenty times the expected run length
   initial
   begin
      repeat (3000) @(posedge clock);
      bad_count++;
      tally_and_finish();
   end
endmodule : io_port_data_path_tb
`default_nettype wire
